// >>> src/spf_regs.vh
// Register indices, field positions and reset values of the serial framing port
`ifndef SPF_REGS_VH
`define SPF_REGS_VH

// ==================================================================
// Register indices (byte address is four times the index)
`define SPF_IDX_CTRL 24'hFFE260
`define SPF_IDX_DATA 24'hFFE261
`define SPF_IDX_CMD 24'hFFE262
`define SPF_IDX_MODE 24'hFFE263
`define SPF_IDX_STAT 24'hFFE264
`define SPF_IDX_BAUD 24'hFFE266

// ==================================================================
// Control register fields
`define SPF_CTRL_EN_LSB 0
`define SPF_CTRL_MASTER_ENABLE_BIT 2
`define SPF_CTRL_RGC_BIT 3
`define SPF_CTRL_RST 8'h00

// ==================================================================
// Transmit command register fields
`define SPF_CMD_SSV_BIT 0
`define SPF_CMD_TRANSMIT_END_OF_FRAME_BIT 1

// ==================================================================
// Mode register fields
`define SPF_MODE_FSM_LSB 5
`define SPF_MODE_WID_LSB 2
`define SPF_MODE_DIR_BIT 1
`define SPF_MODE_POL_BIT 0
`define SPF_MODE_RST 8'h00

// ==================================================================
// Frame select modes
`define SPF_FSM_SPI 3'h0
`define SPF_FSM_LOOP 3'h1
`define SPF_FSM_I2S 3'h2

// ==================================================================
// Status register fields
`define SPF_ST_TX_HOLDING_EMPTY 7
`define SPF_ST_TX_UNDERRUN 6
`define SPF_ST_COL 5
`define SPF_ST_ABT 4
`define SPF_ST_RX_OVERRUN 3
`define SPF_ST_RX_HOLDING_FULL 2
`define SPF_ST_TRANSFER_ACTIVE 1
`define SPF_ST_SELECT_DEASSERTED_VIEW 0
`define SPF_STAT_RST 8'h01

// ==================================================================
// Rate generator reload, and I2S lead count: data follows after this many plus one falling SCK edges
`define SPF_BAUD_RST 16'hFFFF
`define SPF_I2S_LEAD 2'h1

`endif

// >>> src/spf_port.v
// Serial port with SPI, loopback and I2S framing, status flags and APB registers
`timescale 1ns/1ps
`include "spf_regs.vh"

// Function
// - SPI mode with select output: pin driven from the held select value bit.
// - End-of-frame bit on last byte clears select value when character ends.
// - SPI mode SCK toggles only during transfer, one clock per bit.
// - Loopback master: outputs idle, shift output fed back to shift input.
// - Loopback slave: while selected, slave data output echoes slave data input.
// - I2S master: select placed two SCK periods ahead, held until next frame.
// - I2S master: SCK runs continuously, select change marks frames, back to back.
// - I2S slave: any select level change starts transaction on next SCK cycle.
// - Width field: 000 shifts eight bits, 001..111 shift one to seven.
// - Select direction 0 makes select pin input, 1 makes it output.
// - Polarity 0 active low select, polarity 1 active high select.
// - Disabled port returns every status bit to its reset value.
// - Underrun, collision, abort, overrun flags clear on written one or when disabled.
// - Transmit-empty bit 7 set when holding empty, cleared by write, 0 disabled.
// - Receive-full bit 2 set on new character, cleared by data read.
// - Slave abort when select deasserts before all character bits transfer, outside I2S mode.
// - Slave abort also on SCK monitor time-out with rate generator bit set.
// - Collision flag set on multi-master mode fault, held until cleared.
// - Transfer status reads one while a transfer is in progress.
// - Select status is pin level XOR polarity; reset value one.
// - Master sends MOSI, receives MISO, drives SCK; slave does the reverse.
// - Enabled slave with rate generator bit uses it as SCK time-out monitor.
module spf_port #(
  parameter AW = 32
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [AW-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire sck_in,
  output reg sck_out,
  output reg sck_oe,
  input wire mosi_in,
  output reg mosi_out,
  output reg mosi_oe,
  input wire miso_in,
  output reg miso_out,
  output reg miso_oe,
  input wire ss_in,
  output reg ss_out,
  output reg ss_oe
);

  localparam ST_IDLE = 2'h0;
  localparam ST_DLY = 2'h1;
  localparam ST_BITS = 2'h2;

  // ==================================================================
  // Registers
  reg [7:0] ctrl_reg;
  reg [7:0] mode_reg;
  reg [15:0] baud_reg;
  reg ssv_reg;
  reg transmit_end_of_frame_reg;
  reg [7:0] hold_reg;
  reg hold_full_reg;
  reg [7:0] rx_reg;
  reg tx_underrun_reg;
  reg col_reg;
  reg abt_reg;
  reg rx_overrun_reg;
  reg rx_holding_full_reg;
  reg [3:0] sync1_reg;
  reg [3:0] sync2_reg;
  reg sck_prev_reg;
  reg ss_prev_reg;
  reg [1:0] state_reg;
  reg [7:0] sh_reg;
  reg rx_bit_reg;
  reg [3:0] cnt_reg;
  reg [1:0] dly_reg;
  reg transmit_end_of_frame_cur_reg;
  reg frame_ssv_reg;
  reg sck_ph_reg;
  reg sck_run_reg;
  reg [15:0] div_reg;
  reg [15:0] tmo_reg;
  reg [31:0] rd_mux;
  reg hit;

  // ==================================================================
  // Input synchronisers: sck, mosi, miso, ss
  wire [3:0] pins_in = {ss_in, miso_in, mosi_in, sck_in};
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1_reg[gi] <= (gi == 3) ? 1'b1 : 1'b0;
          sync2_reg[gi] <= (gi == 3) ? 1'b1 : 1'b0;
        end else begin
          sync1_reg[gi] <= pins_in[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate

  // ==================================================================
  // Decoded configuration
  wire sck_s = sync2_reg[0];
  wire mosi_s = sync2_reg[1];
  wire miso_s = sync2_reg[2];
  wire ss_s = sync2_reg[3];
  wire [1:0] en_mode = ctrl_reg[`SPF_CTRL_EN_LSB+1:`SPF_CTRL_EN_LSB];
  wire enabled = |en_mode;
  wire master = ctrl_reg[`SPF_CTRL_MASTER_ENABLE_BIT];
  wire rgc = ctrl_reg[`SPF_CTRL_RGC_BIT];
  wire [2:0] fmode = mode_reg[`SPF_MODE_FSM_LSB+2:`SPF_MODE_FSM_LSB];
  wire [2:0] width = mode_reg[`SPF_MODE_WID_LSB+2:`SPF_MODE_WID_LSB];
  wire ss_dir = mode_reg[`SPF_MODE_DIR_BIT];
  wire pol = mode_reg[`SPF_MODE_POL_BIT];
  wire is_i2s = (fmode == `SPF_FSM_I2S);
  wire is_loop = (fmode == `SPF_FSM_LOOP);
  // Last bit index of a character; width code 0 means eight bits
  wire [3:0] last_bit = (width == 3'h0) ? 4'h7 : ({1'b0, width} - 4'h1);
  // Select is asserted when the pin level equals the polarity bit
  wire sel_asserted = (ss_s == pol);
  wire sck_rise = sck_s & ~sck_prev_reg;
  wire sck_fall = ~sck_s & sck_prev_reg;
  wire ss_change = (ss_s != ss_prev_reg);
  // Master receives on MISO, slave on MOSI
  wire sdi = master ? miso_s : mosi_s;

  // ==================================================================
  // APB access decode; one wait state then pready
  wire [23:0] idx = paddr[25:2];
  wire acc = psel & penable & pready;
  wire wr_acc = acc & pwrite & hit;
  wire rd_acc = acc & ~pwrite & hit;

  // Register address decode and read mux
  always @* begin
    hit = 1'b1;
    rd_mux = 32'h0000_0000;
    case (idx)
      `SPF_IDX_CTRL: rd_mux = {24'h000000, ctrl_reg};
      `SPF_IDX_DATA: rd_mux = {24'h000000, rx_reg};
      `SPF_IDX_CMD: rd_mux = {30'h0000_0000, transmit_end_of_frame_reg, ssv_reg};
      `SPF_IDX_MODE: rd_mux = {24'h000000, mode_reg};
      `SPF_IDX_STAT: rd_mux = {24'h000000, enabled & ~hold_full_reg, tx_underrun_reg, col_reg,
        abt_reg, rx_overrun_reg, rx_holding_full_reg, state_reg != ST_IDLE,
        enabled ? (ss_s ^ pol) : 1'b1};
      `SPF_IDX_BAUD: rd_mux = {16'h0000, baud_reg};
      default: hit = 1'b0;
    endcase
  end

  // Rate generator half-period tick; reload 0 gives 65536
  wire [15:0] div_inc = div_reg + 16'h0001;
  wire tick = (div_inc == baud_reg);
  wire clk_run = master & ((state_reg != ST_IDLE) | (sck_run_reg & is_i2s));
  wire rd_clear = rd_acc & (idx == `SPF_IDX_DATA);
  wire [7:0] rx_done = {sh_reg[6:0], rx_bit_reg};
  // Master samples at the falling tick, after pin and synchroniser delay
  wire [7:0] mst_done = {sh_reg[6:0], is_loop ? sh_reg[7] : sdi};
  // A transmit write beats a load in the same cycle
  wire data_wr = wr_acc & (idx == `SPF_IDX_DATA);

  // ==================================================================
  // Bus interface, configuration, status flags and shift engine
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      ctrl_reg <= `SPF_CTRL_RST;
      mode_reg <= `SPF_MODE_RST;
      baud_reg <= `SPF_BAUD_RST;
      ssv_reg <= 1'b0;
      transmit_end_of_frame_reg <= 1'b0;
      hold_reg <= 8'h00;
      hold_full_reg <= 1'b0;
      rx_reg <= 8'h00;
      tx_underrun_reg <= 1'b0;
      col_reg <= 1'b0;
      abt_reg <= 1'b0;
      rx_overrun_reg <= 1'b0;
      rx_holding_full_reg <= 1'b0;
      sck_prev_reg <= 1'b0;
      ss_prev_reg <= 1'b1;
      state_reg <= ST_IDLE;
      sh_reg <= 8'h00;
      rx_bit_reg <= 1'b0;
      cnt_reg <= 4'h0;
      dly_reg <= 2'h0;
      transmit_end_of_frame_cur_reg <= 1'b0;
      frame_ssv_reg <= 1'b0;
      sck_ph_reg <= 1'b0;
      sck_run_reg <= 1'b0;
      div_reg <= 16'h0000;
      tmo_reg <= 16'h0000;
      sck_out <= 1'b0;
      sck_oe <= 1'b0;
      mosi_out <= 1'b0;
      mosi_oe <= 1'b0;
      miso_out <= 1'b0;
      miso_oe <= 1'b0;
      ss_out <= 1'b1;
      ss_oe <= 1'b0;
    end else begin
      sck_prev_reg <= sck_s;
      ss_prev_reg <= ss_s;
      // Bus handshake: pready one cycle after the access phase opens
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~hit;
      if (psel & penable & ~pready & ~pwrite) begin
        prdata <= rd_mux;
      end
      // Software writes
      if (wr_acc) begin
        case (idx)
          `SPF_IDX_CTRL: ctrl_reg <= pwdata[7:0];
          `SPF_IDX_MODE: mode_reg <= pwdata[7:0];
          `SPF_IDX_BAUD: baud_reg <= pwdata[15:0];
          `SPF_IDX_CMD: begin
            ssv_reg <= pwdata[`SPF_CMD_SSV_BIT];
            transmit_end_of_frame_reg <= pwdata[`SPF_CMD_TRANSMIT_END_OF_FRAME_BIT];
          end
          `SPF_IDX_DATA: begin
            hold_reg <= pwdata[7:0];
            hold_full_reg <= 1'b1;
          end
          `SPF_IDX_STAT: begin
            if (pwdata[`SPF_ST_TX_UNDERRUN]) tx_underrun_reg <= 1'b0;
            if (pwdata[`SPF_ST_COL]) col_reg <= 1'b0;
            if (pwdata[`SPF_ST_ABT]) abt_reg <= 1'b0;
            if (pwdata[`SPF_ST_RX_OVERRUN]) rx_overrun_reg <= 1'b0;
          end
          default: ;
        endcase
      end
      if (rd_clear) begin
        rx_holding_full_reg <= 1'b0;
      end
      // Rate generator: half-period divider in master, SCK monitor in slave
      if (clk_run) begin
        div_reg <= tick ? 16'h0000 : div_inc;
        if (tick) sck_ph_reg <= ~sck_ph_reg;
      end else begin
        div_reg <= 16'h0000;
        sck_ph_reg <= 1'b0;
      end
      // Mode fault: external select asserted while master with select input
      if (enabled & master & ~ss_dir & sel_asserted) begin
        col_reg <= 1'b1;
      end
      if (!enabled) begin
        // Disabled: idle engine, status back to reset values
        state_reg <= ST_IDLE;
        hold_full_reg <= 1'b0;
        tx_underrun_reg <= 1'b0;
        col_reg <= 1'b0;
        abt_reg <= 1'b0;
        rx_overrun_reg <= 1'b0;
        rx_holding_full_reg <= 1'b0;
        sck_run_reg <= 1'b0;
      end else if (master) begin
        case (state_reg)
          ST_IDLE: begin
            if (hold_full_reg) begin
              sh_reg <= hold_reg;
              hold_full_reg <= data_wr;
              transmit_end_of_frame_cur_reg <= transmit_end_of_frame_reg;
              cnt_reg <= 4'h0;
              if (is_i2s) begin
                frame_ssv_reg <= ssv_reg;
                sck_run_reg <= 1'b1;
                dly_reg <= 2'h0;
                state_reg <= ST_DLY;
              end else begin
                state_reg <= ST_BITS;
              end
            end
          end
          ST_DLY: begin
            // Select leads data by two full SCK periods
            if (tick & sck_ph_reg) begin
              dly_reg <= dly_reg + 2'h1;
              if (dly_reg == `SPF_I2S_LEAD) state_reg <= ST_BITS;
            end
          end
          ST_BITS: begin
            if (tick & sck_ph_reg) begin
              // Falling edge: sample late in the high phase, then shift
              sh_reg <= mst_done;
              cnt_reg <= cnt_reg + 4'h1;
              if (cnt_reg == last_bit) begin
                rx_reg <= mst_done;
                rx_holding_full_reg <= 1'b1;
                if (rx_holding_full_reg & ~rd_clear) rx_overrun_reg <= 1'b1;
                if (transmit_end_of_frame_cur_reg) ssv_reg <= 1'b0;
                if (is_i2s & hold_full_reg) begin
                  // Back-to-back frames; a select change opens a new frame
                  sh_reg <= hold_reg;
                  hold_full_reg <= data_wr;
                  transmit_end_of_frame_cur_reg <= transmit_end_of_frame_reg;
                  cnt_reg <= 4'h0;
                  if (ssv_reg != frame_ssv_reg) begin
                    frame_ssv_reg <= ssv_reg;
                    dly_reg <= 2'h0;
                    state_reg <= ST_DLY;
                  end
                end else begin
                  if (is_i2s) tx_underrun_reg <= 1'b1;
                  state_reg <= ST_IDLE;
                end
              end
            end
          end
          default: state_reg <= ST_IDLE;
        endcase
      end else begin
        // Slave engine
        case (state_reg)
          ST_IDLE: begin
            tmo_reg <= 16'h0000;
            if (is_i2s ? ss_change : sel_asserted) begin
              cnt_reg <= 4'h0;
              state_reg <= ST_BITS;
              if (hold_full_reg) begin
                sh_reg <= hold_reg;
                hold_full_reg <= data_wr;
              end else begin
                // Nothing to send: all ones; flag unless receive-only
                sh_reg <= 8'hFF;
                if (en_mode != 2'h1) tx_underrun_reg <= 1'b1;
              end
            end
          end
          ST_BITS: begin
            tmo_reg <= (sck_rise | sck_fall) ? 16'h0000 : tmo_reg + 16'h0001;
            if (!is_i2s & !sel_asserted) begin
              abt_reg <= 1'b1;
              state_reg <= ST_IDLE;
            end else if (rgc & (tmo_reg == baud_reg)) begin
              abt_reg <= 1'b1;
              state_reg <= ST_IDLE;
            end else if (sck_rise) begin
              rx_bit_reg <= sdi;
            end else if (sck_fall) begin
              sh_reg <= rx_done;
              cnt_reg <= cnt_reg + 4'h1;
              if (cnt_reg == last_bit) begin
                rx_reg <= rx_done;
                rx_holding_full_reg <= 1'b1;
                if (rx_holding_full_reg & ~rd_clear) rx_overrun_reg <= 1'b1;
                state_reg <= ST_IDLE;
              end
            end
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
      // Pin drivers
      sck_oe <= enabled & master;
      sck_out <= sck_ph_reg & ~is_loop;
      mosi_oe <= enabled & master;
      mosi_out <= (state_reg != ST_IDLE) & ~is_loop & sh_reg[7];
      miso_oe <= enabled & ~master & sel_asserted;
      miso_out <= is_loop ? mosi_s : sh_reg[7];
      ss_oe <= enabled & ss_dir;
      if (is_loop & master) begin
        ss_out <= ~pol;
      end else if (is_i2s) begin
        ss_out <= ~(frame_ssv_reg ^ pol);
      end else begin
        ss_out <= ~(ssv_reg ^ pol);
      end
    end
  end

endmodule

// >>> dv/spf_checker.sv
// Port-level assertions for the serial framing port, bound to its top module
`timescale 1ns/1ps
`include "spf_regs.vh"
module spf_checker #(
  parameter AW = 32
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [AW-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire sck_oe,
  input wire mosi_oe,
  input wire miso_oe,
  input wire ss_oe
);
  // ==================================================================
  // Shadow of control and mode, and cycles since either was written
  wire [23:0] idx = paddr[25:2];
  wire wr = psel && penable && pready && !pslverr && pwrite;
  wire cfg_wr = wr && (idx == `SPF_IDX_CTRL || idx == `SPF_IDX_MODE);
  wire mapped = idx == `SPF_IDX_CTRL || idx == `SPF_IDX_DATA || idx == `SPF_IDX_CMD ||
    idx == `SPF_IDX_MODE || idx == `SPF_IDX_STAT || idx == `SPF_IDX_BAUD;
  reg [7:0] ctrl_reg;
  reg [7:0] mode_reg;
  reg [2:0] age_reg;
  wire en = ctrl_reg[1:0] != 2'h0;
  wire mst = en && ctrl_reg[2];
  wire settled = age_reg >= 3'h4;
  wire rd_done = pready && !pwrite;

  // Update shadows on the edge where a write lands
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `SPF_CTRL_RST;
      mode_reg <= `SPF_MODE_RST;
      age_reg <= 3'h0;
    end else begin
      if (wr && idx == `SPF_IDX_CTRL) ctrl_reg <= pwdata[7:0];
      if (wr && idx == `SPF_IDX_MODE) mode_reg <= pwdata[7:0];
      if (cfg_wr) age_reg <= 3'h0;
      else if (age_reg != 3'h7) age_reg <= age_reg + 3'h1;
    end
  end

  // ==================================================================
  // Properties
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rdy_wait;
    $rose(psel && penable) |-> !pready ##1 pready;
  endproperty
  property p_rdy_pulse;
    pready |=> !pready;
  endproperty
  property p_err_rdy;
    pslverr |-> pready;
  endproperty
  property p_err_map;
    pready |-> pslverr == !mapped;
  endproperty
  property p_stat_off;
    rd_done && idx == `SPF_IDX_STAT && !en && settled |-> prdata[7:0] == `SPF_STAT_RST;
  endproperty
  property p_mode_rd;
    rd_done && idx == `SPF_IDX_MODE |-> prdata[7:0] == mode_reg;
  endproperty
  property p_mst_oe;
    settled |-> sck_oe == mst && mosi_oe == mst;
  endproperty
  property p_ss_oe;
    settled |-> ss_oe == (en && mode_reg[`SPF_MODE_DIR_BIT]);
  endproperty
  property p_miso_oe;
    settled && miso_oe |-> en && !ctrl_reg[2];
  endproperty
  a_rdy_wait: assert property (p_rdy_wait) else $error("pready not after one wait state");
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready longer than one cycle");
  a_err_rdy: assert property (p_err_rdy) else $error("pslverr without pready");
  a_err_map: assert property (p_err_map) else $error("pslverr does not match address map");
  a_stat_off: assert property (p_stat_off) else $error("status not at reset value");
  a_mode_rd: assert property (p_mode_rd) else $error("mode readback wrong");
  a_mst_oe: assert property (p_mst_oe) else $error("master drive enables wrong");
  a_ss_oe: assert property (p_ss_oe) else $error("select pin direction wrong");
  a_miso_oe: assert property (p_miso_oe) else $error("slave output while master");
  c_master: cover property (sck_oe);
  c_slave: cover property (miso_oe);
  c_err: cover property (pready && pslverr);
endmodule

bind spf_port spf_checker #(.AW(AW)) u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .sck_oe, .mosi_oe, .miso_oe, .ss_oe);

// >>> dv/spf_spi_partner.sv
// Behavioural SPI slave on the far side of the port, clock mode 0, MSB first
`timescale 1ns/1ps
module spf_spi_partner (
  input wire sck,
  input wire ss_n,
  input wire mosi,
  input wire [7:0] reply,
  output reg miso = 1'b0,
  output reg [7:0] got = 8'h00,
  output reg [3:0] edges = 4'h0
);
  reg [7:0] shift_reg = 8'h00;
  // Frame start loads the reply, first bit out at once
  always @(negedge ss_n) begin
    shift_reg = reply;
    miso = reply[7];
    got = 8'h00;
    edges = 4'h0;
  end
  // Sample master data on rising clock
  always @(posedge sck) begin
    if (!ss_n) begin
      got = {got[6:0], mosi};
      edges = edges + 4'h1;
    end
  end
  // Next bit on falling clock
  always @(negedge sck) begin
    if (!ss_n) begin
      shift_reg = {shift_reg[6:0], 1'b1};
      miso = shift_reg[7];
    end
  end
  // Released line shows the inverse of its last bit
  always @(posedge ss_n) miso = ~miso;
endmodule

// >>> dv/test_spf_port.sv
// Self-checking bench for the serial framing port with an SPI slave partner
`timescale 1ns/1ps
`include "spf_regs.vh"
module test_spf_port;
  typedef struct packed {
    logic [2:0] code;
    logic [3:0] n;
    logic [7:0] tx;
    logic [7:0] reply;
    logic [7:0] rx;
  } spf_row_t;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, q;
  logic sck_drv = 1'b0, mosi_drv = 1'b0, ss_drv = 1'b1, e;
  logic [7:0] part_reply = 8'h00;
  wire [31:0] prdata;
  wire pready, pslverr, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, ss_out, ss_oe;
  wire part_miso;
  wire [7:0] part_got;
  wire [3:0] part_edges;
  int errors = 0, total_checks = 0;
  spf_row_t rows [4];
  // Pin levels from each party's enable; idle select pulled up
  wire sck_pin = sck_oe ? sck_out : sck_drv;
  wire mosi_pin = mosi_oe ? mosi_out : mosi_drv;
  wire miso_pin = miso_oe ? miso_out : part_miso;
  wire ss_pin = ss_oe ? ss_out : ss_drv;

  spf_port #(.AW(32)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sck_in(sck_pin), .sck_out(sck_out), .sck_oe(sck_oe),
    .mosi_in(mosi_pin), .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_pin),
    .miso_out(miso_out), .miso_oe(miso_oe), .ss_in(ss_pin), .ss_out(ss_out), .ss_oe(ss_oe));
  spf_spi_partner u_far (.sck(sck_pin), .ss_n(ss_pin), .mosi(mosi_pin), .reply(part_reply),
    .miso(part_miso), .got(part_got), .edges(part_edges));

  // Clock
  initial begin
    forever #2 pclk = ~pclk;
  end

  // ==================================================================
  // Compare, bus cycle, status poll and verdict
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [23:0] idx, input logic [15:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {6'h00, idx, 2'h0};
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Wait for pready; only the watchdog ends a hung access
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_bit(input int b);
    int k;
    k = 0;
    do begin
      apb(1'b0, `SPF_IDX_STAT, 16'h0000);
      k++;
    end while (q[b] !== 1'b1 && k < 200);
    chk("status wait", 1'b1, q[b]);
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (40000) @(posedge pclk);
    errors++;
    print_verdict;
  end

  // ==================================================================
  // Main sequence
  initial begin
    rows = '{'{3'h0, 4'h8, 8'hA5, 8'h3C, 8'h3C}, '{3'h1, 4'h1, 8'h80, 8'h80, 8'h01},
      '{3'h3, 4'h3, 8'hE0, 8'h40, 8'h02}, '{3'h7, 4'h7, 8'h5A, 8'hC6, 8'h63}};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `SPF_IDX_STAT, 16'h0000);
    chk("stat reset", 32'h01, q);
    apb(1'b0, `SPF_IDX_MODE, 16'h0000);
    chk("mode reset", 32'h00, q);
    apb(1'b0, 24'hFFE26F, 16'h0000);
    chk("unmapped err", 1'b1, e);
    chk("unmapped data", 32'h0, q);
    apb(1'b1, `SPF_IDX_BAUD, 16'h0002);
    apb(1'b1, `SPF_IDX_CTRL, 16'h0007);
    foreach (rows[i]) begin
      part_reply <= rows[i].reply;
      apb(1'b1, `SPF_IDX_MODE, {11'h000, rows[i].code, 2'h2});
      apb(1'b1, `SPF_IDX_CMD, 16'h0003);
      repeat (4) @(posedge pclk);
      chk("select low", 1'b0, ss_pin);
      apb(1'b1, `SPF_IDX_DATA, {8'h00, rows[i].tx});
      wait_bit(2);
      chk("sck edges", rows[i].n, part_edges);
      chk("slave got", rows[i].tx >> (8 - rows[i].n), part_got & (8'hFF >> (8 - rows[i].n)));
      chk("select freed", 1'b1, ss_pin);
      apb(1'b0, `SPF_IDX_STAT, 16'h0000);
      chk("tx_holding_empty", 1'b1, q[7]);
      chk("busy", 1'b0, q[1]);
      apb(1'b0, `SPF_IDX_DATA, 16'h0000);
      chk("rx data", rows[i].rx, q[7:0]);
      apb(1'b0, `SPF_IDX_STAT, 16'h0000);
      chk("rx_holding_full clear", 1'b0, q[2]);
    end
    // Two characters without reading; overrun flag set and cleared by one
    repeat (2) begin
      apb(1'b1, `SPF_IDX_CMD, 16'h0003);
      apb(1'b1, `SPF_IDX_DATA, 16'h0055);
      wait_bit(2);
    end
    wait_bit(3);
    chk("overrun set", 1'b1, q[3]);
    apb(1'b1, `SPF_IDX_STAT, 16'h0000);
    apb(1'b0, `SPF_IDX_STAT, 16'h0000);
    chk("overrun kept", 1'b1, q[3]);
    apb(1'b1, `SPF_IDX_STAT, 16'h0008);
    apb(1'b0, `SPF_IDX_STAT, 16'h0000);
    chk("overrun cleared", 1'b0, q[3]);
    apb(1'b0, `SPF_IDX_DATA, 16'h0000);
    // Active high select
    apb(1'b1, `SPF_IDX_MODE, 16'h0003);
    apb(1'b1, `SPF_IDX_CMD, 16'h0001);
    repeat (4) @(posedge pclk);
    chk("select high", 1'b1, ss_pin);
    apb(1'b0, `SPF_IDX_STAT, 16'h0000);
    chk("select_deasserted_view asserted", 1'b0, q[0]);
    apb(1'b1, `SPF_IDX_CMD, 16'h0000);
    repeat (4) @(posedge pclk);
    chk("select idle", 1'b0, ss_pin);
    apb(1'b0, `SPF_IDX_STAT, 16'h0000);
    chk("select_deasserted_view idle", 1'b1, q[0]);
    // Loopback master rotates its own character back into receive
    apb(1'b1, `SPF_IDX_MODE, 16'h0022);
    apb(1'b1, `SPF_IDX_DATA, 16'h00C3);
    wait_bit(2);
    chk("loop sck idle", 1'b0, sck_pin);
    apb(1'b0, `SPF_IDX_DATA, 16'h0000);
    chk("loop rx", 32'hC3, q);
    // I2S master: select held after the frame, underrun with nothing queued
    apb(1'b1, `SPF_IDX_MODE, 16'h0042);
    apb(1'b1, `SPF_IDX_CMD, 16'h0001);
    apb(1'b1, `SPF_IDX_DATA, 16'h0096);
    wait_bit(2);
    chk("i2s select held", 1'b0, ss_pin);
    chk("i2s underrun", 1'b1, q[6]);
    // Foreign select while master, then disable
    apb(1'b1, `SPF_IDX_MODE, 16'h0000);
    ss_drv <= 1'b0;
    repeat (8) @(posedge pclk);
    apb(1'b0, `SPF_IDX_STAT, 16'h0000);
    chk("collision", 1'b1, q[5]);
    ss_drv <= 1'b1;
    apb(1'b1, `SPF_IDX_CTRL, 16'h0000);
    apb(1'b0, `SPF_IDX_STAT, 16'h0000);
    chk("stat disabled", 8'h01, q[7:0]);
    // Loopback slave echo, then select lost after three clocks
    apb(1'b1, `SPF_IDX_MODE, 16'h0020);
    apb(1'b1, `SPF_IDX_CTRL, 16'h0003);
    ss_drv <= 1'b0;
    mosi_drv <= 1'b1;
    repeat (10) @(posedge pclk);
    chk("echo one", 1'b1, miso_pin);
    mosi_drv <= 1'b0;
    repeat (10) @(posedge pclk);
    chk("echo zero", 1'b0, miso_pin);
    repeat (6) begin
      repeat (20) @(posedge pclk);
      sck_drv <= ~sck_drv;
    end
    ss_drv <= 1'b1;
    repeat (10) @(posedge pclk);
    apb(1'b0, `SPF_IDX_STAT, 16'h0000);
    chk("abort", 1'b1, q[4]);
    print_verdict;
  end
endmodule
